/* inc/lcn_pkg.sv */
// Constants and carrier types of the line change notifier
`default_nettype none
package lcn_pkg;
	localparam int CLK_NS = 40;
	localparam int MS_NS = 1000000;
	localparam int STABLE_MS = 20;
	localparam int MS_CYCLES = MS_NS / CLK_NS;
	localparam int FILTER_TICKS = STABLE_MS + 1;
	localparam int CNT_W = 5;
	localparam int DIV_W = 24;
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam int BIT_GEN_ZERO = 0;
	localparam int BIT_GEN_ONE = 1;
	localparam int BIT_DSR = 2;
	localparam int BIT_DTR = 3;
	localparam int BIT_CTS = 4;
	localparam int BIT_RTS = 5;
	localparam int BIT_GEN_SIX = 6;
	localparam int BIT_GEN_SEVEN = 7;

	// Packed MSB first so each field lands on its mask bit
	typedef struct packed {
		logic general_line_seven;
		logic general_line_six;
		logic rts;
		logic cts;
		logic dtr;
		logic dsr;
		logic general_line_one;
		logic general_line_zero;
	} lcn_lines_s;

	typedef struct packed {
		logic [7:0] changed;
		logic [7:0] level;
	} lcn_notice_s;
endpackage : lcn_pkg
`default_nettype wire

/* rtl/lcn_line_filter.sv */
// Stability filter for one monitored line
`default_nettype none
module lcn_line_filter
	import lcn_pkg::*;
(
	input wire logic clk, // System clock
	input wire logic rst_n, // Synchronised reset, active low
	input wire logic tick, // One-millisecond enable
	input wire logic enable, // Mask bit of this line
	input wire logic reseed, // Reload state from the line
	input wire logic level_in, // Synchronised line level
	output logic state_r, // Filtered state
	output logic change // One-cycle change pulse
);
	logic [CNT_W-1:0] cnt_r;
	logic hit;

	assign hit = enable && !reseed && (level_in != state_r) && tick
		&& (cnt_r == CNT_W'(FILTER_TICKS - 1));
	assign change = hit;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			state_r <= 1'b0;
		else if (reseed || !enable || hit)
			state_r <= level_in;
	end

	// Any return to the filtered level restarts the count
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			cnt_r <= '0;
		else if (reseed || !enable || level_in == state_r)
			cnt_r <= '0;
		else if (tick)
			cnt_r <= cnt_r + CNT_W'(1);
	end
endmodule : lcn_line_filter
`default_nettype wire

/* rtl/lcn_notifier.sv */
// Line change notifier: mask setting, filters and notice output
`default_nettype none
module lcn_notifier
	import lcn_pkg::*;
#(
	parameter int MS_CYCLES_P = MS_CYCLES
)
(
	input wire logic clk, // System clock, 25 MHz
	input wire logic rstn, // Asynchronous reset, active low
	input wire lcn_lines_s lines, // Monitored line pins
	input wire logic set_valid, // Store set_value as the mask setting
	input wire logic [7:0] set_value, // New mask setting
	input wire logic init_req, // Initialise the mask setting
	input wire logic reboot_req, // Apply the stored setting and restart
	input wire logic conn_up, // Data connection established
	input wire logic notice_ready, // Host side takes the notice
	output logic [7:0] mask_setting, // Stored mask setting for reading
	output logic [7:0] active_mask, // Mask in effect
	output logic notice_valid, // Notice waiting
	output lcn_notice_s notice // Changed lines and their levels
);
	logic rst_meta_r;
	logic rst_n;
	logic [7:0] pin_meta_r;
	logic [7:0] pin_sync_r;
	logic seed_r;
	logic [DIV_W-1:0] div_r;
	logic tick;
	logic reseed;
	logic [7:0] filt;
	logic [7:0] chg;
	logic [7:0] pend_r;
	logic [7:0] pend_nxt;
	logic take;
	logic load;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rst_meta_r <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_meta_r <= 1'b1;
			rst_n <= rst_meta_r;
		end
	end

	// Pin synchroniser; two register stages for each of the eight lines
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_meta_r <= 8'h00;
			pin_sync_r <= 8'h00;
		end
		else
		begin
			pin_meta_r <= lines;
			pin_sync_r <= pin_meta_r;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			seed_r <= 1'b1;
		else
			seed_r <= 1'b0;
	end

	// Millisecond enable
	assign tick = (div_r == DIV_W'(MS_CYCLES_P - 1));

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			div_r <= '0;
		else if (tick)
			div_r <= '0;
		else
			div_r <= div_r + DIV_W'(1);
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			mask_setting <= MASK_RESET;
		else if (init_req)
			mask_setting <= MASK_RESET;
		else if (set_valid)
			mask_setting <= set_value;
	end

	// A new setting only takes effect at reboot
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			active_mask <= MASK_RESET;
		else if (reboot_req)
			active_mask <= mask_setting;
	end

	assign reseed = seed_r || reboot_req;

	for (genvar i = 0; i < 8; i++)
	begin : g_line
		lcn_line_filter u_filt (
			.clk(clk),
			.rst_n(rst_n),
			.tick(tick),
			.enable(active_mask[i]),
			.reseed(reseed),
			.level_in(pin_sync_r[i]),
			.state_r(filt[i]),
			.change(chg[i])
		);
	end

	assign take = notice_valid && notice_ready;
	assign load = (!notice_valid || take) && conn_up && !reboot_req && (pend_r != 8'h00);

	// New changes are kept even in the cycle the pending set is taken
	always_comb
	begin
		pend_nxt = load ? chg : (pend_r | chg);
		if (!conn_up || reboot_req)
			pend_nxt = 8'h00;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			pend_r <= 8'h00;
		else
			pend_r <= pend_nxt;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			notice_valid <= 1'b0;
		else if (!conn_up || reboot_req)
			notice_valid <= 1'b0;
		else if (load)
			notice_valid <= 1'b1;
		else if (take)
			notice_valid <= 1'b0;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			notice <= '0;
		else if (load)
			notice <= '{changed: pend_r, level: filt};
	end

	// Mismatch age of line zero, for the stability check
	int mis_cnt;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			mis_cnt <= 0;
		else if (active_mask[0] && !reseed && pin_sync_r[0] != filt[0])
			mis_cnt <= mis_cnt + 1;
		else
			mis_cnt <= 0;
	end

	sequence s_notice_up;
		$rose(notice_valid);
	endsequence

	sequence s_notice_stall;
		notice_valid && !notice_ready && conn_up && !reboot_req;
	endsequence

	a_set_store: assert property (@(posedge clk) disable iff (!rst_n)
		set_valid && !init_req |=> mask_setting == $past(set_value))
		else $error("mask setting not stored");
	a_init_zero: assert property (@(posedge clk) disable iff (!rst_n)
		init_req |=> mask_setting == 8'h00)
		else $error("mask setting not cleared by init");
	a_mask_apply: assert property (@(posedge clk) disable iff (!rst_n)
		reboot_req |=> active_mask == $past(mask_setting))
		else $error("mask not applied at reboot");
	a_mask_hold: assert property (@(posedge clk) disable iff (!rst_n)
		!reboot_req |=> $stable(active_mask))
		else $error("mask changed without reboot");
	a_masked_quiet: assert property (@(posedge clk) disable iff (!rst_n)
		(chg & ~active_mask) == 8'h00)
		else $error("change on a disabled line");
	a_filter_time: assert property (@(posedge clk) disable iff (!rst_n)
		chg[0] |-> mis_cnt >= STABLE_MS * MS_CYCLES_P)
		else $error("change reported before 20 ms");
	a_one_change: assert property (@(posedge clk) disable iff (!rst_n)
		chg[0] |=> !chg[0] && filt[0] == $past(pin_sync_r[0]))
		else $error("filtered state not updated once");
	a_notice_cause: assert property (@(posedge clk) disable iff (!rst_n)
		s_notice_up |-> $past(conn_up) && notice.changed != 8'h00
			&& (notice.changed & ~active_mask) == 8'h00)
		else $error("notice without connection or cause");
	a_notice_hold: assert property (@(posedge clk) disable iff (!rst_n)
		s_notice_stall |=> notice_valid && $stable(notice))
		else $error("notice dropped while waiting");
	a_change_sent: assert property (@(posedge clk) disable iff (!rst_n)
		chg[0] && conn_up && !notice_valid && pend_r == 8'h00 ##1 conn_up && !reboot_req
			|=> notice_valid && notice.changed[0])
		else $error("change did not reach the notice");
endmodule : lcn_notifier
`default_nettype wire

/* test/lcn_host_model.sv */
// Network host model taking change notices
`default_nettype none
module lcn_host_model
	import lcn_pkg::*;
(
	input wire logic clk, // System clock
	input wire logic link, // Connection wanted
	input wire logic notice_valid, // Notice offered
	output logic conn_up, // Connection established
	output logic notice_ready, // Takes the notice
	output int taken // Notices taken
);
	timeunit 1ns;
	timeprecision 1ps;
	logic ready_r = 1'b0;
	int taken_r = 0;
	assign conn_up = link;
	assign notice_ready = ready_r;
	assign taken = taken_r;
	// Random stalls give prompt and slow takes
	always @(posedge clk)
	begin
		if (notice_valid && notice_ready)
			taken_r <= taken_r + 1;
		ready_r <= #1 ($urandom_range(0, 2) == 0);
	end
endmodule : lcn_host_model
`default_nettype wire

/* test/test_lcn_notifier.sv */
// Self-checking bench of the line change notifier
`default_nettype none
module test_lcn_notifier
	import lcn_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int MSP = 4;
	logic clk = 1'b0, rstn = 1'b0, set_valid = 1'b0, init_req = 1'b0;
	logic reboot_req = 1'b0, link = 1'b1, notice_valid, conn_up, notice_ready;
	logic [7:0] set_value = 8'h00, mask_setting, active_mask, r;
	lcn_lines_s lines = '0;
	lcn_notice_s notice;
	int taken, mismatches = 0, checks = 0, n, cnt;
	lcn_notifier #(.MS_CYCLES_P(MSP)) i_lcn_notifier (.clk(clk), .rstn(rstn),
		.lines(lines), .set_valid(set_valid), .set_value(set_value),
		.init_req(init_req), .reboot_req(reboot_req), .conn_up(conn_up),
		.notice_ready(notice_ready), .mask_setting(mask_setting),
		.active_mask(active_mask), .notice_valid(notice_valid), .notice(notice));
	lcn_host_model i_lcn_host_model (.clk(clk), .link(link),
		.notice_valid(notice_valid), .conn_up(conn_up),
		.notice_ready(notice_ready), .taken(taken));
	initial
	begin
		forever #20 clk = ~clk;
	end
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : check
	task automatic complete_run();
		$display("checks %0d, mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : complete_run
	function automatic logic [7:0] one_hot(input int b);
		return 8'h01 << b;
	endfunction : one_hot
	task automatic cycles(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : cycles
	// Store a setting, then reboot so that it takes effect
	task automatic apply(input logic [7:0] v);
		logic [7:0] old;
		old = active_mask;
		set_valid = 1'b1;
		set_value = v;
		cycles(1);
		set_valid = 1'b0;
		check("mask_setting", mask_setting, v);
		check("active_mask", active_mask, old);
		reboot_req = 1'b1;
		cycles(1);
		reboot_req = 1'b0;
		check("active_mask", active_mask, v);
	endtask : apply
	task automatic await_notice(input int b);
		cnt = 0;
		while (notice_valid !== 1'b1 && cnt < 200)
		begin
			cycles(1);
			cnt++;
		end
		check("delay", cnt >= 20 * MSP && cnt <= 22 * MSP + 8, 1);
		check("changed", notice.changed, one_hot(b));
		check("level", notice.level[b], lines[b]);
	endtask : await_notice
	initial
	begin
		r = 8'($urandom(93555));
		cycles(20);
		rstn = 1'b1;
		cycles(4);
		check("mask_setting", mask_setting, MASK_RESET);
		check("notice_valid", notice_valid, 0);
		// Disabled lines toggle at random beside the enabled one
		for (int b = 0; b < 8; b++)
		begin
			apply(one_hot(b));
			r = 8'($urandom());
			r[b] = 1'b1;
			lines = lines ^ r;
			await_notice(b);
		end
		// Output-only lines stay disabled; an RTS toggle and an 18 ms DSR pulse must stay silent
		apply(8'hD7);
		n = taken;
		lines = lines ^ (one_hot(BIT_DSR) | one_hot(BIT_RTS));
		cycles(18 * MSP);
		lines.dsr = ~lines.dsr;
		cycles(30 * MSP);
		check("pulse", taken - n, 0);
		check("notice_valid", notice_valid, 0);
		link = 1'b0;
		lines.cts = ~lines.cts;
		cycles(30 * MSP);
		link = 1'b1;
		cycles(2);
		check("dropped", taken - n, 0);
		set_valid = 1'b1;
		init_req = 1'b1;
		cycles(1);
		set_valid = 1'b0;
		init_req = 1'b0;
		check("mask_setting", mask_setting, 8'h00);
		check("active_mask", active_mask, 8'hD7);
		complete_run();
	end
	initial
	begin
		#(40 * 5000);
		mismatches++;
		complete_run();
	end
endmodule : test_lcn_notifier
`default_nettype wire
